// file: core/ufl_pkg.sv
// Behaviour
// - Transmit trigger codes give 16, 8, 24, 30
// - Transmit event on falling below trigger, else empty
// - Receive trigger codes give 8, 16, 24, 28
// - Transfer-mode bit stored, no behavioural effect
// - Transmit FIFO reset clears level, self-clears
// - Receive FIFO reset clears level, self-clears
// - Bit 0 enables FIFOs; otherwise other bits ignored
// - Line bit 7 selects divisor latches
// - Line bit 6 holds transmit output low
// - Line bit 3 enables parity send and check
// - Line bit 4 picks odd or even
// - Line bit 5 forces parity to mark/space
// - Stop bits one, one-and-half, or two
// - Line bits 1:0 give 5 to 8 bits
// - Modem bit 7 prescales baud clock by four
// - Infrared enable loads strap at reset release
// - Infrared coder in path, idle output low
// - Feature bit 4 inverts infrared receive input
// - FIFO control register reads back FIFO enable in bits 7:6, 1 in bits 5:0
// - Latest trigger write governs both directions
package ufl_pkg;

	// ----------------------------------------------------------------
	// Register offsets and field positions.
	// ----------------------------------------------------------------
	localparam logic [3:0] AD_DATA    = 4'h0; // Data, or divisor low byte.
	localparam logic [3:0] AD_DIVHI   = 4'h1; // Divisor high byte.
	localparam logic [3:0] AD_FIFO    = 4'h2; // FIFO control, or divisor fraction.
	localparam logic [3:0] AD_LINE    = 4'h3; // Line control.
	localparam logic [3:0] AD_MODEM   = 4'h4; // Modem control.
	localparam logic [3:0] AD_FEAT    = 4'h8; // Feature control.
	localparam int FC_ENABLE  = 0;  // FIFO enable bit.
	localparam int FC_RXRST   = 1;  // Receive FIFO reset bit.
	localparam int FC_TXRST   = 2;  // Transmit FIFO reset bit.
	localparam int FC_DMA     = 3;  // Legacy transfer-mode bit.
	localparam int FC_TXSEL   = 4;  // Low bit of transmit trigger select.
	localparam int FC_RXSEL   = 6;  // Low bit of receive trigger select.
	localparam int LC_STOP    = 2;  // Stop length bit.
	localparam int LC_PAREN   = 3;  // Parity enable bit.
	localparam int LC_EVEN    = 4;  // Even parity bit.
	localparam int LC_FORCE   = 5;  // Forced parity bit.
	localparam int LC_BREAK   = 6;  // Break bit.
	localparam int LC_DLAB    = 7;  // Divisor access bit.
	localparam int MC_IRDA    = 6;  // Infrared enable bit.
	localparam int MC_PRESC   = 7;  // Prescaler bit.
	localparam int FT_RXINV   = 4;  // Infrared receive inversion bit.
	localparam logic [7:0] RST_REG = 8'h00; // Reset value of every stored register.

	// ----------------------------------------------------------------
	// Trigger tables and timing.
	// ----------------------------------------------------------------
	localparam logic [5:0] TX_TRIG0 = 6'h10;
	localparam logic [5:0] TX_TRIG1 = 6'h08;
	localparam logic [5:0] TX_TRIG2 = 6'h18;
	localparam logic [5:0] TX_TRIG3 = 6'h1e;
	localparam logic [5:0] RX_TRIG0 = 6'h08;
	localparam logic [5:0] RX_TRIG1 = 6'h10;
	localparam logic [5:0] RX_TRIG2 = 6'h18;
	localparam logic [5:0] RX_TRIG3 = 6'h1c;
	localparam logic [1:0] PRESC_LAST = 2'h3; // Divide by four wraps at three.
	localparam logic [3:0] IR_PULSE   = 4'h3; // Infrared pulse, ticks of sixteen.
	localparam logic [3:0] IR_BIT     = 4'hf; // Last tick of one bit time.
	localparam logic [2:0] STOP_ONE   = 3'h2; // Stop length in half bits.
	localparam logic [2:0] STOP_ONEH  = 3'h3;
	localparam logic [2:0] STOP_TWO   = 3'h4;
	localparam logic [3:0] DATA_MIN   = 4'h5; // Shortest character.

	typedef enum logic [2:0] {
		PAR_NONE  = 3'b000,
		PAR_ODD   = 3'b001,
		PAR_EVEN  = 3'b010,
		PAR_MARK  = 3'b011,
		PAR_SPACE = 3'b100
	} uflParity_e;

	// Character format handed to the shifters.
	typedef struct packed {
		logic [3:0] dataBits;
		logic [2:0] stopHalves;
		uflParity_e parity;
	} uflLineFmt_s;

	// One host access.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] data;
	} uflBusReq_s;

endpackage

// file: core/ufl_fifo_level.sv
`timescale 1ns/1ns
// Level counter of one FIFO with trigger detection.
module ufl_fifo_level
	import ufl_pkg::*;
#(
	parameter int DEPTH = 32
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       flush,
	input  wire logic       push,
	input  wire logic       pop,
	input  wire logic [5:0] trigLevel,
	output logic [5:0]      count,
	output logic            atTrig,
	output logic            fallEvent
);

	if (DEPTH < 2 || DEPTH > 63) begin : badDepth
		$error("DEPTH must lie in 2..63");
	end

	localparam logic [5:0] FULL = 6'(DEPTH);

	typedef struct packed {
		logic [5:0] count;      // Characters held.
		logic       filledOver; // Last refill went above the trigger.
		logic       atTrig;     // Count at or above trigger.
		logic       fall;       // Transmit-ready event.
	} uflLevel_s;

	uflLevel_s stateReg;
	uflLevel_s stateNext;

	// Counts pushes and pops, and fires when the level falls away.
	always_comb begin
		logic inOk;
		logic outOk;
		inOk = push && (stateReg.count != FULL);
		outOk = pop && (stateReg.count != 6'h00);
		stateNext = stateReg;
		stateNext.fall = 1'b0;
		if (flush) begin
			stateNext.count = 6'h00;
			stateNext.filledOver = 1'b0;
		end else if (inOk && !outOk) begin
			stateNext.count = stateReg.count + 6'h01;
			if (stateNext.count > trigLevel) begin
				stateNext.filledOver = 1'b1;
			end
		end else if (outOk && !inOk) begin
			stateNext.count = stateReg.count - 6'h01;
			// Falling below the trigger after an overfill fires once.
			if (stateReg.filledOver && stateNext.count < trigLevel) begin
				stateNext.fall = 1'b1;
				stateNext.filledOver = 1'b0;
			end
			// Becoming empty by a pop always fires; a flush does not.
			if (stateNext.count == 6'h00) begin
				stateNext.fall = 1'b1;
			end
		end
		stateNext.atTrig = stateNext.count >= trigLevel;
		if (srst) begin
			stateNext = '0;
		end
	end

	// Registers the state.
	always_ff @(posedge clk) begin
		stateReg <= stateNext;
	end

	assign count = stateReg.count;
	assign atTrig = stateReg.atTrig;
	assign fallEvent = stateReg.fall;

	empty_fire_a: assert property (@(posedge clk) disable iff (srst)
		(count == 6'h01 && pop && !push && !flush) |=> fallEvent && count == 6'h00)
		else $error("emptying did not fire the event");

endmodule

// file: core/ufl_irda_coder.sv
`timescale 1ns/1ns
// Infrared pulse encoder and decoder on a sixteen-tick bit time.
module ufl_irda_coder
	import ufl_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic enable,
	input  wire logic rxInvert,
	input  wire logic sampleTick,
	input  wire logic txRaw,
	input  wire logic rxPin,
	output logic      txCoded,
	output logic      rxRaw
);

	typedef struct packed {
		logic [3:0] txPhase; // Tick position within the sent bit.
		logic       txLast;  // Previous raw transmit bit.
		logic [3:0] rxHold;  // Ticks left of a stretched zero.
		logic       rxBusy;  // A pulse is being stretched.
		logic       txCoded;
		logic       rxRaw;
	} uflIrda_s;

	uflIrda_s stateReg;
	uflIrda_s stateNext;

	// Zero bits send a short pulse; a received pulse reads as a zero bit.
	always_comb begin
		logic light;
		light = rxPin ^ rxInvert;
		stateNext = stateReg;
		stateNext.txLast = txRaw;
		if (txRaw != stateReg.txLast) begin
			stateNext.txPhase = 4'h0;
		end else if (sampleTick) begin
			stateNext.txPhase = stateReg.txPhase + 4'h1;
		end
		// Idle and one bits leave the output low.
		stateNext.txCoded = enable && !txRaw && (stateNext.txPhase < IR_PULSE);
		if (light) begin
			stateNext.rxBusy = 1'b1;
			stateNext.rxHold = IR_BIT;
		end else if (sampleTick && stateReg.rxBusy) begin
			stateNext.rxHold = stateReg.rxHold - 4'h1;
			stateNext.rxBusy = stateReg.rxHold != 4'h0;
		end
		stateNext.rxRaw = enable ? !stateNext.rxBusy : rxPin;
		if (srst) begin
			stateNext = '0;
			stateNext.rxRaw = 1'b1;
		end
	end

	// Registers the state.
	always_ff @(posedge clk) begin
		stateReg <= stateNext;
	end

	assign txCoded = stateReg.txCoded;
	assign rxRaw = stateReg.rxRaw;

	idle_low_a: assert property (@(posedge clk) disable iff (srst)
		txRaw |=> !txCoded)
		else $error("infrared output not low on a one bit");

endmodule

// file: core/ufl_line_config.sv
`timescale 1ns/1ns
// FIFO control, line control and modem control of one serial channel.
module ufl_line_config
	import ufl_pkg::*;
#(
	parameter int DEPTH = 32
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  uflBusReq_s       busReq,
	output logic [7:0]       rdData,
	output logic             rdValid,
	input  wire logic        infraredEnableStrap,
	input  wire logic        txShiftPop,
	input  wire logic        rxShiftPush,
	input  wire logic        txIrqClear,
	input  wire logic        sampleTick,
	input  wire logic        txSerial,
	input  wire logic        rxPin,
	output logic             txPin,
	output logic             rxSerial,
	output uflLineFmt_s      lineFmt,
	output logic [23:0]      divisor,
	output logic             divisorAccess,
	output logic             prescaleTick,
	output logic             fifoEnable,
	output logic             dmaMode,
	output logic [5:0]       txTrigLevel,
	output logic [5:0]       rxTrigLevel,
	output logic [5:0]       txCount,
	output logic [5:0]       rxCount,
	output logic             txIrq,
	output logic             rxTrigHit
);

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  lineReg;      // Line control register.
		logic [7:0]  modemReg;     // Modem control register.
		logic [7:0]  featReg;      // Feature control register.
		logic [7:0]  divLow;       // Divisor low byte.
		logic [7:0]  divHigh;      // Divisor high byte.
		logic [7:0]  divFrac;      // Divisor fraction.
		logic        fifoEn;       // FIFOs enabled.
		logic        dma;          // Legacy transfer mode.
		logic [1:0]  txSel;        // Transmit trigger code.
		logic [1:0]  rxSel;        // Receive trigger code.
		logic        txFlush;      // Transmit FIFO reset pulse.
		logic        rxFlush;      // Receive FIFO reset pulse.
		logic        strapPending; // Strap still to be caught.
		logic [1:0]  preCnt;       // Prescaler phase.
		logic        preTick;      // Baud generator enable.
		logic        txIrq;        // Sticky transmit-ready event.
		logic        txLine;       // Transmit pin level.
		logic        rxLine;       // Receive bit to the shifter.
		uflLineFmt_s fmt;          // Decoded character format.
		logic [5:0]  txTrig;       // Transmit trigger level.
		logic [5:0]  rxTrig;       // Receive trigger level.
		logic [7:0]  rdData;       // Read answer.
		logic        rdValid;      // Read answer valid.
	} uflCfg_s;

	uflCfg_s stateReg;
	uflCfg_s stateNext;

	logic       txFall;  // Transmit level event.
	logic       rxAtTrig; // Receive level at trigger.
	logic       irTx;    // Encoded transmit bit.
	logic       irRx;    // Decoded receive bit.
	logic       dlab;    // Divisor access selected.
	logic       thrWrite; // Host writes a transmit character.
	logic       rhrRead; // Host reads a receive character.

	assign dlab = stateReg.lineReg[LC_DLAB];
	assign thrWrite = busReq.wr && busReq.addr == AD_DATA && !dlab;
	assign rhrRead = busReq.rd && busReq.addr == AD_DATA && !dlab;

	// ----------------------------------------------------------------
	// FIFO levels and infrared coder.
	// ----------------------------------------------------------------
	ufl_fifo_level #(.DEPTH(DEPTH)) txLevel (
		.clk       (clk),
		.srst      (srst),
		.flush     (stateReg.txFlush),
		.push      (thrWrite && stateReg.fifoEn),
		.pop       (txShiftPop),
		.trigLevel (stateReg.txTrig),
		.count     (txCount),
		.atTrig    (),
		.fallEvent (txFall)
	);

	ufl_fifo_level #(.DEPTH(DEPTH)) rxLevel (
		.clk       (clk),
		.srst      (srst),
		.flush     (stateReg.rxFlush),
		.push      (rxShiftPush && stateReg.fifoEn),
		.pop       (rhrRead),
		.trigLevel (stateReg.rxTrig),
		.count     (rxCount),
		.atTrig    (rxAtTrig),
		.fallEvent ()
	);

	ufl_irda_coder irda (
		.clk        (clk),
		.srst       (srst),
		.enable     (stateReg.modemReg[MC_IRDA]),
		.rxInvert   (stateReg.featReg[FT_RXINV]),
		.sampleTick (sampleTick),
		.txRaw      (txSerial),
		.rxPin      (rxPin),
		.txCoded    (irTx),
		.rxRaw      (irRx)
	);

	// ----------------------------------------------------------------
	// Register writes, reads and derived controls.
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] wd;
		wd = busReq.data;
		stateNext = stateReg;
		stateNext.txFlush = 1'b0;
		stateNext.rxFlush = 1'b0;
		stateNext.rdValid = busReq.rd;
		stateNext.rdData = 8'h00;
		// Writes land on the register the address and access bit select.
		if (busReq.wr) begin
			case (busReq.addr)
				AD_DATA: begin
					if (dlab) begin
						stateNext.divLow = wd;
					end
				end
				AD_DIVHI: begin
					if (dlab) begin
						stateNext.divHigh = wd;
					end
				end
				AD_FIFO: begin
					if (dlab) begin
						stateNext.divFrac = wd;
					end else if (wd[FC_ENABLE]) begin
						stateNext.fifoEn = 1'b1;
						stateNext.dma = wd[FC_DMA];
						// Both codes are taken from one write.
						stateNext.txSel = wd[FC_TXSEL +: 2];
						stateNext.rxSel = wd[FC_RXSEL +: 2];
						stateNext.txFlush = wd[FC_TXRST];
						stateNext.rxFlush = wd[FC_RXRST];
					end else begin
						stateNext.fifoEn = 1'b0;
					end
				end
				AD_LINE: begin
					stateNext.lineReg = wd;
				end
				AD_MODEM: begin
					stateNext.modemReg = wd;
				end
				AD_FEAT: begin
					stateNext.featReg = wd;
				end
				default: begin
				end
			endcase
		end
		// Reads return stored registers, zero at the data and divisor-high offsets with the access bit clear; the FIFO control reads as status.
		if (busReq.rd) begin
			case (busReq.addr)
				AD_DATA: begin
					stateNext.rdData = dlab ? stateReg.divLow : 8'h00;
				end
				AD_DIVHI: begin
					stateNext.rdData = dlab ? stateReg.divHigh : 8'h00;
				end
				AD_FIFO: begin
					stateNext.rdData = dlab ? stateReg.divFrac
						: {{2{stateReg.fifoEn}}, 6'h01};
				end
				AD_LINE: begin
					stateNext.rdData = stateReg.lineReg;
				end
				AD_MODEM: begin
					stateNext.rdData = stateReg.modemReg;
				end
				AD_FEAT: begin
					stateNext.rdData = stateReg.featReg;
				end
				default: begin
					stateNext.rdData = 8'h00;
				end
			endcase
		end
		// Trigger tables.
		case (stateNext.txSel)
			2'b00: stateNext.txTrig = TX_TRIG0;
			2'b01: stateNext.txTrig = TX_TRIG1;
			2'b10: stateNext.txTrig = TX_TRIG2;
			default: stateNext.txTrig = TX_TRIG3;
		endcase
		case (stateNext.rxSel)
			2'b00: stateNext.rxTrig = RX_TRIG0;
			2'b01: stateNext.rxTrig = RX_TRIG1;
			2'b10: stateNext.rxTrig = RX_TRIG2;
			default: stateNext.rxTrig = RX_TRIG3;
		endcase
		// Character length and stop length.
		stateNext.fmt.dataBits = DATA_MIN + {2'b00, stateReg.lineReg[1:0]};
		if (!stateReg.lineReg[LC_STOP]) begin
			stateNext.fmt.stopHalves = STOP_ONE;
		end else if (stateReg.lineReg[1:0] == 2'b00) begin
			stateNext.fmt.stopHalves = STOP_ONEH;
		end else begin
			stateNext.fmt.stopHalves = STOP_TWO;
		end
		// Parity selection.
		case (stateReg.lineReg[LC_FORCE:LC_PAREN])
			3'b001: stateNext.fmt.parity = PAR_ODD;
			3'b011: stateNext.fmt.parity = PAR_EVEN;
			3'b101: stateNext.fmt.parity = PAR_MARK;
			3'b111: stateNext.fmt.parity = PAR_SPACE;
			default: stateNext.fmt.parity = PAR_NONE;
		endcase
		// Prescaler divides by one or four.
		if (stateReg.modemReg[MC_PRESC]) begin
			stateNext.preCnt = stateReg.preCnt + 2'h1;
			stateNext.preTick = stateReg.preCnt == PRESC_LAST;
		end else begin
			stateNext.preCnt = 2'h0;
			stateNext.preTick = 1'b1;
		end
		// Sticky transmit event; a new event beats the clear.
		stateNext.txIrq = txFall || (stateReg.txIrq && !txIrqClear && !thrWrite);
		// Break holds the pin low; otherwise raw or encoded bits.
		if (stateReg.lineReg[LC_BREAK]) begin
			stateNext.txLine = 1'b0;
		end else begin
			stateNext.txLine = stateReg.modemReg[MC_IRDA] ? irTx : txSerial;
		end
		stateNext.rxLine = irRx;
		// Strap is caught on the first cycle after reset release.
		if (stateReg.strapPending) begin
			stateNext.modemReg[MC_IRDA] = infraredEnableStrap;
			stateNext.strapPending = 1'b0;
		end
		// Defaults on reset.
		if (srst) begin
			stateNext = '0;
			stateNext.lineReg = RST_REG;
			stateNext.modemReg = RST_REG;
			stateNext.featReg = RST_REG;
			stateNext.strapPending = 1'b1;
			stateNext.txTrig = TX_TRIG0;
			stateNext.rxTrig = RX_TRIG0;
			stateNext.fmt.dataBits = DATA_MIN;
			stateNext.fmt.stopHalves = STOP_ONE;
			stateNext.fmt.parity = PAR_NONE;
			stateNext.txLine = 1'b1;
			stateNext.rxLine = 1'b1;
		end
	end

	// Registers the state.
	always_ff @(posedge clk) begin
		stateReg <= stateNext;
	end

	assign rdData = stateReg.rdData;
	assign rdValid = stateReg.rdValid;
	assign txPin = stateReg.txLine;
	assign rxSerial = stateReg.rxLine;
	assign lineFmt = stateReg.fmt;
	assign divisor = {stateReg.divFrac, stateReg.divHigh, stateReg.divLow};
	assign divisorAccess = dlab;
	assign prescaleTick = stateReg.preTick;
	assign fifoEnable = stateReg.fifoEn;
	assign dmaMode = stateReg.dma;
	assign txTrigLevel = stateReg.txTrig;
	assign rxTrigLevel = stateReg.rxTrig;
	assign txIrq = stateReg.txIrq;
	assign rxTrigHit = rxAtTrig;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	sequence fifoWrite(logic [7:0] v);
		busReq.wr && busReq.addr == AD_FIFO && !dlab && busReq.data == v;
	endsequence

	break_low_a: assert property (@(posedge clk) disable iff (srst)
		stateReg.lineReg[LC_BREAK] |=> !txPin)
		else $error("break did not hold the pin low");

	fifo_gate_a: assert property (@(posedge clk) disable iff (srst)
		fifoWrite(8'h50) |=> !fifoEnable && $stable(txTrigLevel) && $stable(rxTrigLevel))
		else $error("write without enable changed triggers");

	tx_trig_a: assert property (@(posedge clk) disable iff (srst)
		fifoWrite(8'hf9) |=> txTrigLevel == 6'h1e)
		else $error("transmit trigger code 11 not thirty");

	rx_trig_a: assert property (@(posedge clk) disable iff (srst)
		fifoWrite(8'hf9) |=> rxTrigLevel == 6'h1c)
		else $error("receive trigger code 11 not twenty-eight");

	fifo_reset_a: assert property (@(posedge clk) disable iff (srst)
		fifoWrite(8'h17) ##1 !thrWrite |=> txCount == 6'h00 && !stateReg.txFlush)
		else $error("transmit FIFO reset failed");

	stop_half_a: assert property (@(posedge clk) disable iff (srst)
		stateReg.lineReg[2:0] == 3'b100 |=> lineFmt.stopHalves == 3'h3)
		else $error("five-bit long stop not one and a half");

	mark_par_a: assert property (@(posedge clk) disable iff (srst)
		stateReg.lineReg[5:3] == 3'b101 |=> lineFmt.parity == PAR_MARK)
		else $error("forced mark parity not selected");

	// One more quiet cycle after a quiet one, then the next tick.
	sequence prescRest;
		!prescaleTick ##1 !prescaleTick ##1 prescaleTick;
	endsequence

	presc_four_a: assert property (@(posedge clk) disable iff (srst)
		stateReg.modemReg[MC_PRESC] && prescaleTick ##1 stateReg.modemReg[MC_PRESC][*2]
		|-> !$past(prescaleTick) ##0 prescRest)
		else $error("prescaler did not tick one in four");

	fifo_read_a: assert property (@(posedge clk) disable iff (srst)
		busReq.rd && busReq.addr == AD_FIFO && !dlab |=> rdValid && rdData[5:0] == 6'h01)
		else $error("FIFO control contents leaked on read");

endmodule

// file: tb/ufl_remote_model.sv
`timescale 1ns/1ns
// Far-end transceiver: drives the receive pin and watches the transmit pin.
module ufl_remote_model (
	input  wire logic clk,
	input  wire logic irMode,
	input  wire logic sendZero,
	input  wire logic txPin,
	output logic      rxPin,
	output logic      lastTx
);

	// ----------------------------------------------------------------
	// Line drive
	// ----------------------------------------------------------------
	// A zero bit is a low level on a wired line, a light pulse in infrared.
	// Idle rests high on a wired line and dark in infrared.
	always_comb begin
		rxPin = irMode ? sendZero : ~sendZero;
	end

	// Keep the last transmit level for the bench to inspect.
	always_ff @(posedge clk) begin
		lastTx <= txPin;
	end
endmodule

// file: tb/ufl_line_config_tb_top.sv
`timescale 1ns/1ns
// Self-checking bench of the line and FIFO configuration block.
module ufl_line_config_tb_top;
	import ufl_pkg::*;
	logic        clk, srst, strap, pop, push, irqClr, tick, txSer, zero;
	logic        rxPin, txPin, rxSerial, divAcc, pTick, fifoEn, dma, txIrq, rxHit, farTx;
	logic        irMode;
	uflBusReq_s  busReq;
	logic [7:0]  rdData, d;
	logic        rdValid;
	uflLineFmt_s lineFmt;
	logic [23:0] divisor;
	logic [5:0]  txTrig, rxTrig, txCount, rxCount;
	int          bad_count, check_count, cyc, n;
	logic [7:0]  lineIn[6];
	uflLineFmt_s lineExp[6];
	logic [7:0]  fifoIn[4];
	logic [12:0] fifoExp[4];

	ufl_line_config #(.DEPTH(32)) DUT (.clk(clk), .srst(srst), .busReq(busReq),
		.rdData(rdData), .rdValid(rdValid), .infraredEnableStrap(strap),
		.txShiftPop(pop), .rxShiftPush(push), .txIrqClear(irqClr), .sampleTick(tick),
		.txSerial(txSer), .rxPin(rxPin), .txPin(txPin), .rxSerial(rxSerial),
		.lineFmt(lineFmt), .divisor(divisor), .divisorAccess(divAcc),
		.prescaleTick(pTick), .fifoEnable(fifoEn), .dmaMode(dma),
		.txTrigLevel(txTrig), .rxTrigLevel(rxTrig), .txCount(txCount),
		.rxCount(rxCount), .txIrq(txIrq), .rxTrigHit(rxHit));
	ufl_remote_model remote (.clk(clk), .irMode(irMode),
		.sendZero(zero), .txPin(txPin), .rxPin(rxPin), .lastTx(farTx));

	// ----------------------------------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Cuts a hang short after far more cycles than the tests need.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			wrap_up();
		end
	end
	// Compares one value and reports a mismatch.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One host write, entered at a falling edge.
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		busReq = {1'b1, 1'b0, a, v};
		@(negedge clk);
		busReq = '0;
		@(negedge clk);
	endtask
	// One host read; the answer is due one edge after the request.
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		busReq = {1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		busReq = '0;
		check(rdValid, 1);
		v = rdData;
		@(negedge clk);
	endtask
	task automatic idle(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{srst, strap, pop, push, irqClr, txSer, zero} = 7'h62;
		tick = 1'b0; busReq = '0; bad_count = 0; check_count = 0; cyc = 0;
		irMode = 1'b0;
		lineIn = '{8'h00, 8'h1f, 8'h0c, 8'h29, 8'h3a, 8'h36};
		lineExp = '{{4'h5, 3'h2, PAR_NONE}, {4'h8, 3'h4, PAR_EVEN}, {4'h5, 3'h3, PAR_ODD},
			{4'h6, 3'h2, PAR_MARK}, {4'h7, 3'h2, PAR_SPACE}, {4'h7, 3'h4, PAR_NONE}};
		fifoIn = '{8'h01, 8'h59, 8'ha1, 8'hf9};
		fifoExp = '{{6'h10, 6'h08, 1'b0}, {6'h08, 6'h10, 1'b1}, {6'h18, 6'h18, 1'b0},
			{6'h1e, 6'h1c, 1'b1}};
		repeat (12) @(negedge clk);
		srst = 1'b0;
		idle(2);
		check(lineFmt, {4'h5, 3'h2, PAR_NONE});
		check({txTrig, rxTrig, fifoEn, txPin}, {6'h10, 6'h08, 1'b0, 1'b0});
		rd(AD_MODEM, d);
		check(d, 8'h40);
		// The strap turned infrared on; the wired tests want it off.
		wr(AD_MODEM, 8'h00);
		// Table rows: line formats, then FIFO trigger and mode codes.
		for (int i = 0; i < 6; i++) begin
			wr(AD_LINE, lineIn[i]);
			idle(2);
			check(lineFmt, lineExp[i]);
		end
		for (int i = 0; i < 4; i++) begin
			wr(AD_FIFO, fifoIn[i]);
			idle(2);
			check({txTrig, rxTrig, dma}, fifoExp[i]);
		end
		// Divisor access and break.
		wr(AD_LINE, 8'hc3);
		wr(AD_DATA, 8'h34);
		idle(2);
		check({divAcc, divisor[7:0], txPin, farTx}, {1'b1, 8'h34, 1'b0, 1'b0});
		wr(AD_LINE, 8'h03);
		idle(2);
		check({divAcc, txPin}, 2'b01);
		rd(AD_FIFO, d);
		check(d, 8'hc1);
		// A write with the enable bit low leaves triggers alone.
		wr(AD_FIFO, 8'h50);
		idle(2);
		check({fifoEn, txTrig}, {1'b0, 6'h1e});
		wr(AD_FIFO, 8'h11);
		repeat (9) wr(AD_DATA, 8'h55);
		push = 1'b1;
		idle(8);
		push = 1'b0;
		idle(1);
		check({txCount, rxCount, rxHit}, {6'h09, 6'h08, 1'b1});
		pop = 1'b1;
		idle(2);
		pop = 1'b0;
		idle(3);
		check({txIrq, txCount}, {1'b1, 6'h07});
		irqClr = 1'b1;
		idle(1);
		irqClr = 1'b0;
		check(txIrq, 0);
		wr(AD_FIFO, 8'h17);
		idle(2);
		check({txCount, rxCount}, 12'h000);
		// A refill that stays under the trigger still reports the empty FIFO.
		wr(AD_DATA, 8'h5a);
		check({txIrq, txCount}, {1'b0, 6'h01});
		pop = 1'b1;
		idle(1);
		pop = 1'b0;
		idle(2);
		check({txIrq, txCount}, {1'b1, 6'h00});
		// Prescaler: every cycle, then one in four.
		for (int m = 0; m < 2; m++) begin
			wr(AD_MODEM, m ? 8'h80 : 8'h00);
			idle(2);
			n = 0;
			repeat (8) begin
				n += pTick;
				@(negedge clk);
			end
			check(n, m ? 2 : 8);
		end
		// Infrared: transmit rests low, received light shows as a zero.
		wr(AD_MODEM, 8'h40);
		irMode = 1'b1;
		idle(3);
		check(txPin, 0);
		zero = 1'b1;
		repeat (8) begin
			tick = ~tick;
			@(negedge clk);
		end
		check(rxSerial, 0);
		zero = 1'b0;
		// Dark long enough for the stretch to end, then invert the input.
		repeat (40) begin
			tick = ~tick;
			@(negedge clk);
		end
		check(rxSerial, 1);
		wr(AD_FEAT, 8'h10);
		idle(3);
		check(rxSerial, 0);
		wrap_up();
	end
endmodule
